//--- rtl/scmi_pkg.sv
package scmi_pkg;
	// register offsets
	localparam logic [7:0] SCMI_ADDR_SETTING = 8'h17;
	localparam logic [7:0] SCMI_ADDR_CMD     = 8'h18;
	localparam logic [7:0] SCMI_ADDR_RESP    = 8'h20;
	localparam logic [7:0] SCMI_ADDR_FLAGS   = 8'h21;
	localparam logic [7:0] SCMI_ADDR_VIS_LO  = 8'h22;
	localparam logic [7:0] SCMI_ADDR_VIS_HI  = 8'h23;
	// reset values
	localparam logic [7:0] SCMI_RST_BYTE = 8'h00;
	// response codes
	localparam logic [7:0] SCMI_ERR_INVALID = 8'h80;
	localparam logic [7:0] SCMI_ERR_OVF_PS1 = 8'h88;
	localparam logic [7:0] SCMI_ERR_OVF_PS2 = 8'h89;
	localparam logic [7:0] SCMI_ERR_OVF_PS3 = 8'h8A;
	localparam logic [7:0] SCMI_ERR_OVF_VIS = 8'h8C;
	localparam logic [7:0] SCMI_ERR_OVF_IR  = 8'h8D;
	localparam logic [7:0] SCMI_ERR_OVF_AUX = 8'h8E;
	localparam int         SCMI_ERR_BIT     = 7;
	// event flag layout
	localparam int SCMI_FLAG_W   = 6;
	localparam int SCMI_FLAG_CMD = 5;
	localparam int SCMI_FLAG_PS1 = 2;
	localparam int SCMI_PROX_N   = 3;
	// proximity alert style that survives auto clear
	localparam logic [1:0] SCMI_STYLE_KEEP = 2'h3;
	// overflow channel select
	typedef enum logic [2:0] {
		SCMI_CH_PS1, SCMI_CH_PS2, SCMI_CH_PS3, SCMI_CH_VIS, SCMI_CH_IR, SCMI_CH_AUX
	} scmi_chan_type;
	// serial slave states
	typedef enum logic [2:0] {
		SCMI_IDLE, SCMI_ADDR, SCMI_AACK, SCMI_WR, SCMI_WACK, SCMI_RD, SCMI_RACK
	} scmi_i2c_state_type;
endpackage

//--- rtl/scmi_i2c_slave.sv
module scmi_i2c_slave #(
	parameter logic [6:0] DEV_ADDR = 7'h2A
) (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	// serial pins
	input  wire logic       sclIn,
	input  wire logic       sdaIn,
	output logic            sdaOut,
	output logic            sdaOe,
	// register access
	output logic [7:0]      regAddr,
	input  wire logic [7:0] rdData,
	output logic            wrStb,
	output logic [7:0]      wrAddr,
	output logic [7:0]      wrData
);
	import scmi_pkg::*;

	typedef struct packed {
		scmi_i2c_state_type st;
		logic               sclPrev;
		logic               sdaPrev;
		logic [7:0]         shift;
		logic [3:0]         bitCnt;
		logic [7:0]         ptr;
		logic               ptrSet;
		logic               oe;
		logic               wrStb;
		logic [7:0]         wrAddr;
		logic [7:0]         wrData;
	} scmi_i2c_type;

	scmi_i2c_type r;
	scmi_i2c_type next_r;
	logic         rise;
	logic         fall;

	// pin edges; start and stop are sda moving while scl is high
	assign rise = sclIn & ~r.sclPrev;
	assign fall = ~sclIn & r.sclPrev;

	// byte engine: sample on scl rise, drive on scl fall
	always_comb begin
		next_r = r;
		next_r.sclPrev = sclIn;
		next_r.sdaPrev = sdaIn;
		next_r.wrStb = 1'b0;
		if (sclIn && r.sclPrev && r.sdaPrev && !sdaIn) begin
			next_r.st = SCMI_ADDR;
			next_r.bitCnt = 4'h0;
			next_r.ptrSet = 1'b0;
			next_r.oe = 1'b0;
		end else if (sclIn && r.sclPrev && !r.sdaPrev && sdaIn) begin
			next_r.st = SCMI_IDLE;
			next_r.oe = 1'b0;
		end else begin
			case (r.st)
				SCMI_ADDR, SCMI_WR: begin
					if (rise) begin
						next_r.shift = {r.shift[6:0], sdaIn};
						next_r.bitCnt = r.bitCnt + 4'h1;
					end else if (fall && r.bitCnt == 4'h8) begin
						next_r.oe = 1'b1;
						next_r.bitCnt = 4'h0;
						if (r.st == SCMI_ADDR) begin
							next_r.st = (r.shift[7:1] == DEV_ADDR) ? SCMI_AACK : SCMI_IDLE;
							next_r.oe = (r.shift[7:1] == DEV_ADDR);
						end else begin
							next_r.st = SCMI_WACK;
							// first byte of a write sets the pointer
							if (r.ptrSet) begin
								next_r.wrStb = 1'b1;
								next_r.wrAddr = r.ptr;
								next_r.wrData = r.shift;
								next_r.ptr = r.ptr + 8'h01;
							end else begin
								next_r.ptr = r.shift;
								next_r.ptrSet = 1'b1;
							end
						end
					end
				end
				SCMI_AACK, SCMI_RACK: begin
					if (rise && r.st == SCMI_RACK && sdaIn) begin
						next_r.st = SCMI_IDLE;
					end else if (fall && r.st == SCMI_AACK && !r.shift[0]) begin
						next_r.oe = 1'b0;
						next_r.st = SCMI_WR;
					end else if (fall) begin
						next_r.shift = rdData;
						next_r.oe = ~rdData[7];
						next_r.bitCnt = 4'h1;
						next_r.ptr = r.ptr + 8'h01;
						next_r.st = SCMI_RD;
					end
				end
				SCMI_WACK: begin
					if (fall) begin
						next_r.oe = 1'b0;
						next_r.st = SCMI_WR;
					end
				end
				SCMI_RD: begin
					if (fall && r.bitCnt == 4'h8) begin
						next_r.oe = 1'b0;
						next_r.st = SCMI_RACK;
					end else if (fall) begin
						next_r.shift = {r.shift[6:0], 1'b0};
						next_r.oe = ~r.shift[6];
						next_r.bitCnt = r.bitCnt + 4'h1;
					end
				end
				SCMI_IDLE: ;
				default: next_r.st = SCMI_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '{st: SCMI_IDLE, sclPrev: 1'b1, sdaPrev: 1'b1, default: '0};
		end else begin
			r <= next_r;
		end
	end

	// open drain: only ever pulls low
	assign sdaOut = 1'b0;
	assign sdaOe = r.oe;
	assign regAddr = r.ptr;
	assign wrStb = r.wrStb;
	assign wrAddr = r.wrAddr;
	assign wrData = r.wrData;
endmodule

//--- rtl/scmi_event_flags.sv
module scmi_event_flags #(
	parameter int WIDTH = 6
) (
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	// flag control
	input  wire logic [WIDTH-1:0] setBits,
	input  wire logic [WIDTH-1:0] clrBits,
	input  wire logic             autoClr,
	input  wire logic [WIDTH-1:0] keepBits,
	input  wire logic [WIDTH-1:0] alertMask,
	// state
	output logic [WIDTH-1:0]      flags,
	output logic                  alertN
);
	typedef struct packed {
		logic [WIDTH-1:0] flags;
		logic             alertN;
	} scmi_flag_type;

	scmi_flag_type r;
	scmi_flag_type next_r;

	// clear first, then set, so an event in the clear cycle survives
	always_comb begin
		next_r.flags = r.flags & ~clrBits;
		if (autoClr) begin
			next_r.flags = next_r.flags & keepBits;
		end
		next_r.flags = next_r.flags | setBits;
		// RQ13: pin from masked flags
		next_r.alertN = ~|(next_r.flags & alertMask);
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '{flags: '0, alertN: 1'b1};
		end else begin
			r <= next_r;
		end
	end

	assign flags = r.flags;
	assign alertN = r.alertN;

	AST_ALERT_MASKED: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ13
		##1 (alertN == !(|(flags & $past(alertMask)))))
		else $error("alert pin disagrees with masked flags");
	AST_FLAG_STICKY: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ14
		(!autoClr && (flags & ~clrBits) != '0)
		|=> ((flags & $past(flags & ~clrBits)) == $past(flags & ~clrBits)))
		else $error("flag lost without a write of one");
	AST_AUTO_CLEAR: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ15
		(autoClr && setBits == '0) |=> ((flags & ~$past(keepBits)) == '0))
		else $error("auto clear left an unkept flag set");
endmodule

//--- rtl/scmi_mailbox.sv
// Contract
// RQ1: only a write to the command mailbox wakes the device from standby
// RQ2: command mailbox hands codes to the sequencer and resets to zero
// RQ3: errors load the response register with a code whose top bit is one
// RQ4: a held error code stays until a reset or no-op command arrives; a host write to 0x20 also replaces it
// RQ5: while an error is held, commands other than reset or no-op are dropped
// RQ6: autonomous measurement results keep flowing while an error is held
// RQ7: without error, response low nibble counts executed commands and wraps
// RQ8: host polls the rollover counter to confirm each command ran
// RQ9: unrecognised command reports code 0x80
// RQ10: proximity channel one to three overflow reports 0x88, 0x89, 0x8A
// RQ11: visible, infrared and extra channel overflow report 0x8C, 0x8D, 0x8E
// RQ12: flags: command bit 5, proximity 4..2, light field 1..0, 7..6 reserved
// RQ13: alert pin asserts when any flag and its mask bit are both set
// RQ14: clear style zero keeps a flag until the host writes one to it
// RQ15: clear style one auto clears all flags except kept proximity styles
// RQ16: visible-light result low byte at 0x22, high byte at 0x23, reset zero
// RQ17: host reads result bytes after the alert and before the next result
// RQ18: setting mailbox carries parameter values to the sequencer
// RQ19: command flag sets each time the sequencer finishes a command
// RQ20: all registers reachable bytewise over the serial slave by offset
module scmi_mailbox
	import scmi_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR  = 7'h2A,
	parameter logic [7:0] CMD_NOP   = 8'h00,
	parameter logic [7:0] CMD_RESET = 8'h01
) (
	// clock and reset
	input  wire logic                           ref_clk,
	input  wire logic                           rst_n,
	// serial pins
	input  wire logic                           sclIn,
	input  wire logic                           sdaIn,
	output logic                                sdaOut,
	output logic                                sdaOe,
	// sequencer command side
	output logic                                cmdStrobe,
	output logic [7:0]                          cmdCode,
	output logic [7:0]                          settingValue,
	output logic                                awake,
	input  wire logic                           seqDone,
	input  wire logic                           seqCmdInvalid,
	input  wire logic                           seqOvfValid,
	input  wire scmi_pkg::scmi_chan_type        seqOvfChan,
	input  wire logic                           seqStandby,
	// sequencer events and results
	input  wire logic [scmi_pkg::SCMI_PROX_N-1:0] seqProxFlag,
	input  wire logic [1:0]                     seqLightFlag,
	input  wire logic                           seqAutoClear,
	input  wire logic                           visResultValid,
	input  wire logic [15:0]                    visResult,
	// alert configuration
	input  wire logic [scmi_pkg::SCMI_FLAG_W-1:0] alertMask,
	input  wire logic                           clearStyle,
	input  wire logic [2*scmi_pkg::SCMI_PROX_N-1:0] proxAlertStyle,
	// host alert pin
	output logic                                alertN
);
	import scmi_pkg::*;

	typedef struct packed {
		logic [7:0] setting;
		logic [7:0] cmdMbox;
		logic [7:0] response;
		logic [7:0] visLo;
		logic [7:0] visHi;
		logic       cmdStrobe;
		logic       awake;
	} scmi_top_type;

	scmi_top_type           r;
	scmi_top_type           next_r;
	logic [7:0]             regAddr;
	logic [7:0]             rdData;
	logic                   wrStb;
	logic [7:0]             wrAddr;
	logic [7:0]             wrData;
	logic [SCMI_FLAG_W-1:0] flags;
	logic [SCMI_FLAG_W-1:0] setBits;
	logic [SCMI_FLAG_W-1:0] clrBits;
	logic [SCMI_FLAG_W-1:0] keepBits;
	logic                   cmdWrite;
	logic                   clearCmd;
	logic                   errHeld;
	logic                   clrAccept;
	logic [7:0]             ovfCode;

	// serial slave gives byte-wide access by offset
	// RQ20: bytewise register port
	scmi_i2c_slave #(
		.DEV_ADDR (DEV_ADDR)
	) u_slave (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.sclIn   (sclIn),
		.sdaIn   (sdaIn),
		.sdaOut  (sdaOut),
		.sdaOe   (sdaOe),
		.regAddr (regAddr),
		.rdData  (rdData),
		.wrStb   (wrStb),
		.wrAddr  (wrAddr),
		.wrData  (wrData)
	);

	// flag sources in register bit order
	// RQ12: flag field layout
	// RQ19: completion sets command flag
	assign setBits = {seqDone, seqProxFlag, seqLightFlag};

	// write of one clears; also legal under clear style one
	// RQ14: write one to clear
	assign clrBits = (wrStb && wrAddr == SCMI_ADDR_FLAGS) ? wrData[SCMI_FLAG_W-1:0] : '0;

	// per channel keep mask for auto clear
	// RQ15: keep proximity style 11
	genvar gi;
	generate
		for (gi = 0; gi < SCMI_PROX_N; gi++) begin : g_keep
			assign keepBits[SCMI_FLAG_PS1+gi] = (proxAlertStyle[2*gi+:2] == SCMI_STYLE_KEEP);
		end
	endgenerate
	assign keepBits[SCMI_FLAG_CMD] = 1'b0;
	assign keepBits[1:0] = 2'b00;

	scmi_event_flags #(
		.WIDTH (SCMI_FLAG_W)
	) u_flags (
		.ref_clk   (ref_clk),
		.rst_n     (rst_n),
		.setBits   (setBits),
		.clrBits   (clrBits),
		.autoClr   (clearStyle & seqAutoClear),
		.keepBits  (keepBits),
		.alertMask (alertMask),
		.flags     (flags),
		.alertN    (alertN)
	);

	// command write decode; shared by the update and the checks
	assign cmdWrite = wrStb && wrAddr == SCMI_ADDR_CMD;
	assign clearCmd = (wrData == CMD_NOP) || (wrData == CMD_RESET);
	assign errHeld = r.response[SCMI_ERR_BIT];
	assign clrAccept = cmdWrite && errHeld && clearCmd;

	// overflow channel to response code
	always_comb begin
		case (seqOvfChan)
			// RQ10: proximity overflow codes
			SCMI_CH_PS1: ovfCode = SCMI_ERR_OVF_PS1;
			SCMI_CH_PS2: ovfCode = SCMI_ERR_OVF_PS2;
			SCMI_CH_PS3: ovfCode = SCMI_ERR_OVF_PS3;
			// RQ11: light channel overflow codes
			SCMI_CH_VIS: ovfCode = SCMI_ERR_OVF_VIS;
			SCMI_CH_IR:  ovfCode = SCMI_ERR_OVF_IR;
			default:     ovfCode = SCMI_ERR_OVF_AUX;
		endcase
	end

	// read mux; unmapped offsets and reserved flag bits read zero
	always_comb begin
		case (regAddr)
			SCMI_ADDR_SETTING: rdData = r.setting;
			SCMI_ADDR_CMD:     rdData = r.cmdMbox;
			SCMI_ADDR_RESP:    rdData = r.response;
			SCMI_ADDR_FLAGS:   rdData = {2'b00, flags};
			SCMI_ADDR_VIS_LO:  rdData = r.visLo;
			SCMI_ADDR_VIS_HI:  rdData = r.visHi;
			default:           rdData = 8'h00;
		endcase
	end

	// register update; sequencer reports other than standby are applied after host writes
	// so a sequencer report is never overwritten by a host write in the same cycle
	always_comb begin
		next_r = r;
		next_r.cmdStrobe = 1'b0;
		// standby entry loses to a wake in the same cycle
		if (seqStandby) begin
			next_r.awake = 1'b0;
		end
		if (wrStb) begin
			case (wrAddr)
				// RQ18: setting mailbox
				SCMI_ADDR_SETTING: next_r.setting = wrData;
				SCMI_ADDR_CMD: begin
					next_r.cmdMbox = wrData;
					// RQ1: command write wakes
					next_r.awake = 1'b1;
					// RQ5: drop while error held
					if (!errHeld || clearCmd) begin
						// RQ2: forward to sequencer
						next_r.cmdStrobe = 1'b1;
					end
					// RQ4: reset or no-op releases error
					if (clrAccept) begin
						next_r.response = SCMI_RST_BYTE;
					end
				end
				SCMI_ADDR_RESP:   next_r.response = wrData;
				SCMI_ADDR_VIS_LO: next_r.visLo = wrData;
				SCMI_ADDR_VIS_HI: next_r.visHi = wrData;
				default: ;
			endcase
		end
		// RQ7: rollover count per executed command
		if (seqDone && !next_r.response[SCMI_ERR_BIT]) begin
			next_r.response[3:0] = next_r.response[3:0] + 4'h1;
		end
		// RQ9: unrecognised command code
		if (seqCmdInvalid) begin
			next_r.response = SCMI_ERR_INVALID;
		end
		// RQ3: error code has top bit set
		if (seqOvfValid) begin
			next_r.response = ovfCode;
		end
		// RQ6: results land regardless of error
		// RQ16: visible result byte pair
		if (visResultValid) begin
			next_r.visLo = visResult[7:0];
			next_r.visHi = visResult[15:8];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '{default: '0};
		end else begin
			r <= next_r;
		end
	end

	// all outputs straight from flops
	assign cmdStrobe = r.cmdStrobe;
	assign cmdCode = r.cmdMbox;
	assign settingValue = r.setting;
	assign awake = r.awake;

	AST_WAKE_ONLY_BY_CMD: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ1
		$rose(awake) |-> $past(cmdWrite))
		else $error("device woke without a command write");
	AST_CMD_FORWARD: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ2
		(cmdWrite && !errHeld) |=> (cmdStrobe && cmdCode == $past(wrData)))
		else $error("command write not handed to sequencer");
	AST_ERR_HELD: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ4
		(errHeld && !clrAccept && !(wrStb && wrAddr == SCMI_ADDR_RESP))
		|=> r.response[SCMI_ERR_BIT])
		else $error("error code released without reset or no-op");
	AST_IGNORE_IN_ERR: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ5
		(cmdWrite && errHeld && !clearCmd) |=> !cmdStrobe)
		else $error("command forwarded while error held");
	AST_ROLLOVER: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ7
		(seqDone && !errHeld && !wrStb && !seqCmdInvalid && !seqOvfValid)
		|=> (r.response[3:0] == $past(r.response[3:0]) + 4'h1) && !r.response[SCMI_ERR_BIT])
		else $error("rollover counter did not step");
	AST_INVALID_CODE: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ9
		(seqCmdInvalid && !seqOvfValid) |=> (r.response == SCMI_ERR_INVALID))
		else $error("invalid command code not reported");
	AST_OVF_PS1: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ10
		(seqOvfValid && seqOvfChan == SCMI_CH_PS1) |=> (r.response == SCMI_ERR_OVF_PS1))
		else $error("proximity one overflow code wrong");
	AST_OVF_VIS: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ11
		(seqOvfValid && seqOvfChan == SCMI_CH_VIS) |=> (r.response == SCMI_ERR_OVF_VIS))
		else $error("visible overflow code wrong");
	AST_OVF_PS2: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ10
		(seqOvfValid && seqOvfChan == SCMI_CH_PS2) |=> (r.response == SCMI_ERR_OVF_PS2))
		else $error("proximity two overflow code wrong");
	AST_OVF_PS3: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ10
		(seqOvfValid && seqOvfChan == SCMI_CH_PS3) |=> (r.response == SCMI_ERR_OVF_PS3))
		else $error("proximity three overflow code wrong");
	AST_OVF_IR: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ11
		(seqOvfValid && seqOvfChan == SCMI_CH_IR) |=> (r.response == SCMI_ERR_OVF_IR))
		else $error("infrared overflow code wrong");
	AST_OVF_AUX: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ11
		(seqOvfValid && seqOvfChan == SCMI_CH_AUX) |=> (r.response == SCMI_ERR_OVF_AUX))
		else $error("extra channel overflow code wrong");
	AST_ERR_TOP_BIT: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ3
		(seqOvfValid || seqCmdInvalid) |=> r.response[SCMI_ERR_BIT])
		else $error("error code without top bit");
	AST_CMD_FLAG: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ19
		seqDone |=> flags[SCMI_FLAG_CMD])
		else $error("completion flag not set");
	AST_VIS_RESULT: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ16
		visResultValid |=> ({r.visHi, r.visLo} == $past(visResult)))
		else $error("visible result not captured");
endmodule

//--- bench/scmi_host_model.sv
module scmi_host_model #(
	parameter logic [6:0] DEV_ADDR = 7'h2A
) (
	// clock
	input  wire logic ref_clk,
	// serial pins
	input  wire logic sdaLine,
	output logic      sclOut,
	output logic      sdaPull
);
	timeunit 1ns;
	timeprecision 1ns;

	// sticky record of every device acknowledge seen
	logic ackAll = 1'b1;

	// pins idle released so the pull-up holds both high
	initial begin
		sclOut = 1'b1;
		sdaPull = 1'b0;
	end

	// moves just after a clock edge so the device never samples a changing pin
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	// low and high phases kept at four clocks, above the three that the slave needs
	task automatic bitXfer(input logic b, output logic seen);
		sdaPull = ~b;
		tick(2);
		sclOut = 1'b1;
		tick(2);
		seen = sdaLine;
		tick(2);
		sclOut = 1'b0;
		tick(2);
	endtask

	// releasing the line in the ninth slot lets the device acknowledge
	task automatic byteXfer(input logic [7:0] v, input logic chk, output logic [7:0] got);
		logic a;
		for (int i = 7; i >= 0; i--) bitXfer(v[i], got[i]);
		bitXfer(1'b1, a);
		if (chk) ackAll &= ~a;
	endtask

	// also serves as repeated start since data is released first
	task automatic startCond();
		sdaPull = 1'b0;
		tick(2);
		sclOut = 1'b1;
		tick(4);
		sdaPull = 1'b1;
		tick(4);
		sclOut = 1'b0;
		tick(2);
	endtask

	task automatic stopCond();
		sdaPull = 1'b1;
		tick(2);
		sclOut = 1'b1;
		tick(4);
		sdaPull = 1'b0;
		tick(4);
	endtask

	task automatic regWrite(input logic [7:0] addr, input logic [7:0] data);
		logic [7:0] g;
		startCond();
		byteXfer({DEV_ADDR, 1'b0}, 1'b1, g);
		byteXfer(addr, 1'b1, g);
		byteXfer(data, 1'b1, g);
		stopCond();
	endtask

	// byte read by offset, single byte then nack
	task automatic regRead(input logic [7:0] addr, output logic [7:0] d);
		logic [7:0] g;
		startCond();
		byteXfer({DEV_ADDR, 1'b0}, 1'b1, g);
		byteXfer(addr, 1'b1, g);
		startCond();
		byteXfer({DEV_ADDR, 1'b1}, 1'b1, g);
		byteXfer(8'hFF, 1'b0, d);
		stopCond();
	endtask
endmodule

//--- bench/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import scmi_pkg::*;

	// clock, reset and pins
	logic                ref_clk;
	logic                rst_n;
	logic                sclIn;
	logic                hostPull;
	logic                sdaOut;
	logic                sdaOe;
	wire logic           sdaIn = ~(sdaOe | hostPull);
	// sequencer side
	logic                cmdStrobe;
	logic [7:0]          cmdCode;
	logic [7:0]          settingValue;
	logic                awake;
	logic                seqDone;
	logic                seqCmdInvalid;
	logic                seqOvfValid;
	scmi_chan_type       seqOvfChan;
	logic                seqStandby;
	logic [2:0]          seqProxFlag;
	logic [1:0]          seqLightFlag;
	logic                seqAutoClear;
	logic                visResultValid;
	logic [15:0]         visResult;
	logic [5:0]          alertMask;
	logic                clearStyle;
	logic [5:0]          proxAlertStyle;
	logic                alertN;
	// bookkeeping
	int                  errTotal = 0;
	int                  cmpCount = 0;
	int                  strobeCnt = 0;
	int                  s;
	int                  n;
	logic [7:0]          rd;
	logic [7:0]          c;
	logic [5:0]          expF;
	logic [3:0]          expCnt;
	logic [7:0]          errCodes [7] = '{SCMI_ERR_INVALID, SCMI_ERR_OVF_PS1, SCMI_ERR_OVF_PS2,
		SCMI_ERR_OVF_PS3, SCMI_ERR_OVF_VIS, SCMI_ERR_OVF_IR, SCMI_ERR_OVF_AUX};
	logic [7:0]          rstAddrs [7] = '{SCMI_ADDR_SETTING, SCMI_ADDR_CMD, SCMI_ADDR_RESP,
		SCMI_ADDR_FLAGS, SCMI_ADDR_VIS_LO, SCMI_ADDR_VIS_HI, 8'h30};

	scmi_mailbox u_scmi_mailbox (.ref_clk(ref_clk), .rst_n(rst_n), .sclIn(sclIn), .sdaIn(sdaIn),
		.sdaOut(sdaOut), .sdaOe(sdaOe), .cmdStrobe(cmdStrobe), .cmdCode(cmdCode),
		.settingValue(settingValue), .awake(awake), .seqDone(seqDone),
		.seqCmdInvalid(seqCmdInvalid), .seqOvfValid(seqOvfValid), .seqOvfChan(seqOvfChan),
		.seqStandby(seqStandby), .seqProxFlag(seqProxFlag), .seqLightFlag(seqLightFlag),
		.seqAutoClear(seqAutoClear), .visResultValid(visResultValid), .visResult(visResult),
		.alertMask(alertMask), .clearStyle(clearStyle), .proxAlertStyle(proxAlertStyle),
		.alertN(alertN));

	scmi_host_model u_host (.ref_clk(ref_clk), .sdaLine(sdaIn), .sclOut(sclIn), .sdaPull(hostPull));

	// 25 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	// counts command hand-overs, each strobe lasts one cycle
	always @(posedge ref_clk) begin
		if (cmdStrobe === 1'b1) strobeCnt <= strobeCnt + 1;
	end

	function automatic logic alertExp(input logic [5:0] f, input logic [5:0] m);
		return ~|(f & m);
	endfunction

	// proximity flags whose style is 11 survive auto clear
	function automatic logic [5:0] keepExp(input logic [5:0] st);
		logic [5:0] k = '0;
		for (int i = 0; i < 3; i++) k[2 + i] = (st[2*i +: 2] == 2'b11);
		return k;
	endfunction

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			errTotal++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tallyAndFinish();
		if (errTotal == 0 && cmpCount > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// pulses raised by the caller last exactly one edge
	task automatic step();
		@(posedge ref_clk);
		#1;
		seqDone = 1'b0;
		seqCmdInvalid = 1'b0;
		seqOvfValid = 1'b0;
		seqStandby = 1'b0;
		seqAutoClear = 1'b0;
		visResultValid = 1'b0;
		seqProxFlag = '0;
		seqLightFlag = '0;
	endtask

	task automatic readChk(input string what, input logic [7:0] addr, input logic [7:0] exp);
		u_host.regRead(addr, rd);
		check(what, rd, exp);
	endtask

	// hang guard
	initial begin
		repeat (100000) @(posedge ref_clk);
		errTotal++;
		tallyAndFinish();
	end

	initial begin
		rst_n = 1'b0;
		{seqDone, seqCmdInvalid, seqOvfValid, seqStandby, seqAutoClear, visResultValid} = '0;
		{seqProxFlag, seqLightFlag, visResult, alertMask, clearStyle, proxAlertStyle} = '0;
		seqOvfChan = SCMI_CH_PS1;
		void'($urandom(32'hA726CE6E));
		repeat (12) @(posedge ref_clk);
		#1;
		rst_n = 1'b1;
		check("alertN", alertN, 1'b1);
		foreach (rstAddrs[i]) readChk("reset", rstAddrs[i], 8'h00);
		// setting write and flag write leave the device asleep
		c = 8'($urandom);
		u_host.regWrite(SCMI_ADDR_SETTING, c);
		check("setting", settingValue, c);
		u_host.regWrite(SCMI_ADDR_FLAGS, 8'h3F);
		check("awake", awake, 1'b0);
		c = 8'($urandom_range(2, 255));
		u_host.regWrite(SCMI_ADDR_CMD, c);
		check("strobe", 16'(strobeCnt), 16'd1);
		check("cmdCode", cmdCode, c);
		check("awake", awake, 1'b1);
		seqStandby = 1'b1;
		step();
		u_host.regWrite(SCMI_ADDR_SETTING, 8'h5A);
		check("awake", awake, 1'b0);
		// back-to-back completions, wrap at sixteen then a random count
		expCnt = '0;
		for (int k = 0; k < 2; k++) begin
			n = (k == 0) ? 16 : $urandom_range(1, 40);
			seqDone = 1'b1;
			repeat (n - 1) @(posedge ref_clk);
			step();
			expCnt = expCnt + 4'(n);
			readChk("counter", SCMI_ADDR_RESP, {4'h0, expCnt});
		end
		readChk("cmdFlag", SCMI_ADDR_FLAGS, 8'h20);
		// each error source, held against other commands, cleared by no-op or reset
		for (int i = 0; i < 7; i++) begin
			if (i == 0) seqCmdInvalid = 1'b1;
			else begin
				seqOvfValid = 1'b1;
				seqOvfChan = scmi_chan_type'(i - 1);
			end
			step();
			readChk("errCode", SCMI_ADDR_RESP, errCodes[i]);
			s = strobeCnt;
			u_host.regWrite(SCMI_ADDR_CMD, 8'($urandom_range(2, 255)));
			check("ignored", 16'(strobeCnt), 16'(s));
			readChk("errHeld", SCMI_ADDR_RESP, errCodes[i]);
			visResult = 16'($urandom);
			visResultValid = 1'b1;
			step();
			// results read before the next one lands
			readChk("visLo", SCMI_ADDR_VIS_LO, visResult[7:0]);
			readChk("visHi", SCMI_ADDR_VIS_HI, visResult[15:8]);
			c = (i % 2) ? u_scmi_mailbox.CMD_RESET : u_scmi_mailbox.CMD_NOP;
			u_host.regWrite(SCMI_ADDR_CMD, c);
			readChk("errClear", SCMI_ADDR_RESP, 8'h00);
		end
		// random flag events, masked alert and host write-one clears
		u_host.regWrite(SCMI_ADDR_FLAGS, 8'hFF);
		expF = '0;
		repeat (6) begin
			alertMask = 6'($urandom);
			seqProxFlag = 3'($urandom);
			seqLightFlag = 2'($urandom);
			seqDone = 1'($urandom);
			expF = expF | {seqDone, seqProxFlag, seqLightFlag};
			step();
			check("alertSet", alertN, alertExp(expF, alertMask));
			readChk("flags", SCMI_ADDR_FLAGS, {2'b00, expF});
			c = 8'($urandom);
			u_host.regWrite(SCMI_ADDR_FLAGS, c);
			expF = expF & ~c[5:0];
			readChk("flagsClr", SCMI_ADDR_FLAGS, {2'b00, expF});
			check("alertClr", alertN, alertExp(expF, alertMask));
		end
		// auto clear ignored in style zero, honoured in style one
		alertMask = 6'h3F;
		{seqDone, seqProxFlag, seqLightFlag} = 6'h3F;
		step();
		seqAutoClear = 1'b1;
		step();
		readChk("keepAll", SCMI_ADDR_FLAGS, 8'h3F);
		clearStyle = 1'b1;
		proxAlertStyle = 6'($urandom) | 6'h0C;
		seqAutoClear = 1'b1;
		step();
		expF = keepExp(proxAlertStyle);
		readChk("autoClr", SCMI_ADDR_FLAGS, {2'b00, expF});
		check("alertAuto", alertN, alertExp(expF, alertMask));
		// result bytes are host writable
		c = 8'($urandom);
		u_host.regWrite(SCMI_ADDR_VIS_HI, c);
		readChk("visWr", SCMI_ADDR_VIS_HI, c);
		check("ack", u_host.ackAll, 1'b1);
		tallyAndFinish();
	end
endmodule
